// ### bench/dpdiag_properties.sv
// Concurrent checks on the ports of the diagnostic telegram block
module dpdiag_properties #(
    parameter logic [15:0] IDENT_NO = 16'h0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic diag_req,
    input wire logic buf_clear,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idx_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_ff <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            idx_ff <= idx_ff + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_taken;
        tx_valid && tx_ready;
    endsequence
    sequence s_frame_end;
        s_taken ##0 tx_last;
    endsequence
    chk_req_starts: assert property (!tx_valid && diag_req |=> tx_valid)
        else $error("request did not start a telegram");
    chk_last_pos: assert property (tx_valid |-> tx_last == (idx_ff == 4'hF))
        else $error("last flag not on byte 15");
    chk_frame_gap: assert property (s_frame_end |=> !tx_valid)
        else $error("no gap after telegram");
    chk_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("byte changed while stalled");
    chk_state_zero: assert property (tx_valid && idx_ff == 4'h0 |-> !tx_byte[7]
        && !tx_byte[5] && !tx_byte[0])
        else $error("station byte 0 fixed bits wrong");
    chk_state_one: assert property (tx_valid && idx_ff == 4'h1 |-> tx_byte[2] && !tx_byte[7])
        else $error("station byte 1 fixed bits wrong");
    chk_state_two: assert property (tx_valid && idx_ff == 4'h2 |-> tx_byte[6:0] == 7'h00)
        else $error("station byte 2 reserved bits set");
    chk_ident_high: assert property (tx_valid && idx_ff == 4'h4 |-> tx_byte == IDENT_NO[15:8])
        else $error("ident high byte wrong");
    chk_dev_header: assert property (tx_valid && idx_ff == 4'h6 |-> tx_byte == 8'h0A)
        else $error("device header wrong");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access not refused");
    chk_clear_pulse: assert property (buf_clear |=> !buf_clear)
        else $error("clear pulse too long");
endmodule // dpdiag_properties

// ### bench/dpdiag_sink.sv
// Far-end receiver model: takes telegram bytes with random stalls
module dpdiag_sink (
    input wire logic pclk,
    input wire logic presetn,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= ($urandom % 4) != 0;
        end
    end
endmodule // dpdiag_sink

// ### bench/tb_top.sv
// Self-checking bench for the diagnostic telegram block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] IDN = 16'h3C96; // Arbitrary value
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, diag_req, not_ready;
    logic ext_diag, unsupported, need_prm, stat_diag, freeze_held, sync_held, diag_overflow;
    logic prm_done, prm_found, wd_active, xfer_active, cfg_mismatch, wd_expired, hw_fail;
    logic data_exch, buf_clear, tx_valid, tx_last, tx_ready, uval, e;
    logic [7:0] paddr, master_addr, dev_err_code, prm_len_decl, prm_rx_count, tx_byte;
    logic [31:0] pwdata, prdata, r, w;
    logic [3:0] pstrb, errv;
    logic [127:0] got;
    logic [127:0] exp_q[$];
    logic [7:0] ub[1:5];
    int fails, n_tests, nb, nfr, clrs, i, c;
    dpdiag_top #(.IDENT_NO(IDN)) dut_u (.*);
    dpdiag_sink sink_u (.pclk(pclk), .presetn(presetn), .tx_ready(tx_ready));
    assign {hw_fail, wd_expired, cfg_mismatch} = errv[3:1];
    assign xfer_active = ~errv[0];
    function automatic logic pbad();
        return (prm_len_decl != prm_rx_count) || (prm_rx_count > 8'h1F);
    endfunction
    function automatic logic [127:0] tel();
        logic [127:0] t;
        t = '0;
        t[7:0] = {1'b0, pbad(), 1'b0, unsupported, ext_diag, cfg_mismatch, not_ready, 1'b0};
        t[15:8] = {2'b00, sync_held, freeze_held, wd_active, 1'b1, stat_diag, need_prm};
        t[23:16] = {diag_overflow, 7'h00};
        t[31:24] = prm_done ? master_addr : 8'hFF;
        t[47:32] = {IDN[7:0], IDN[15:8]};
        t[55:48] = 8'h0A;
        t[63:56] = (dev_err_code != 8'h00) ? dev_err_code : (uval ? 8'h40 : 8'h00);
        t[127:88] = {ub[5], ub[4], ub[3], ub[2], ub[1]};
        return t;
    endfunction
    function automatic logic [31:0] comm(input logic clr);
        return {16'h0000, 3'b000, data_exch, hw_fail, wd_expired, cfg_mismatch, pbad(),
            4'h0, xfer_active, wd_active, prm_found, clr};
    endfunction
    task automatic chk(input logic [127:0] g, input logic [127:0] x, input string m);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic trig_wait(input int n);
        int f;
        f = nfr + n;
        repeat (300) begin
            if (nfr < f) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic req_frame();
        @(posedge pclk);
        {not_ready, ext_diag, unsupported, need_prm, stat_diag, freeze_held, sync_held,
            diag_overflow, prm_done, wd_active, prm_found, data_exch} <= 12'($urandom);
        master_addr <= 8'($urandom);
        @(posedge pclk);
        exp_q.push_back(tel());
        diag_req <= 1'b1;
        @(posedge pclk);
        diag_req <= 1'b0;
        trig_wait(1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (buf_clear === 1'b1) begin
            clrs++;
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got[8 * nb +: 8] = tx_byte;
            nb++;
            if (nb == 16) begin
                nb = 0;
                nfr++;
                if (exp_q.size() == 0) begin
                    chk(1, 0, "stray telegram");
                end else begin
                    chk(got, exp_q.pop_front(), "telegram");
                end
            end
        end
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (6000) @(posedge pclk);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
    initial begin
        {psel, penable, pwrite, diag_req, uval, not_ready, ext_diag, unsupported} = '0;
        {need_prm, stat_diag, freeze_held, sync_held, diag_overflow, prm_done} = '0;
        {prm_found, wd_active, data_exch, paddr, pwdata, master_addr, dev_err_code} = '0;
        {errv, fails, n_tests, nb, nfr, clrs} = '0;
        presetn = 1'b0;
        pstrb = 4'hF;
        prm_len_decl = 8'h1F;
        prm_rx_count = 8'h1F;
        void'($urandom(15859));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0, r, e);
        chk(r, 0, "status reset");
        w = $urandom;
        apb(1, 8'h04, w, r, e);
        {ub[4], ub[3], ub[2], ub[1]} = w;
        ub[5] = w[15:8];
        apb(1, 8'h08, {24'h00_0000, ub[5]}, r, e);
        apb(0, 8'h04, 0, r, e);
        chk(r, w, "user low");
        apb(0, 8'h08, 0, r, e);
        chk(r, {24'h00_0000, ub[5]}, "user high");
        apb(0, 8'h0C, 0, r, e);
        chk(r, comm(0), "comm idle");
        apb(1, 8'h40, 32'hFFFF_FFFF, r, e);
        chk(e, 1, "unmapped");
        $display("test registers done");
        for (i = 0; i < 3; i++) req_frame();
        exp_q.push_back(tel());
        exp_q.push_back(tel());
        diag_req <= 1'b1;
        @(posedge pclk);
        diag_req <= 1'b0;
        repeat (3) @(posedge pclk);
        diag_req <= 1'b1;
        @(posedge pclk);
        diag_req <= 1'b0;
        trig_wait(2);
        for (c = 8'h12; c <= 8'h17; c++) begin
            dev_err_code <= 8'(c);
            req_frame();
        end
        $display("test requests done");
        dev_err_code <= 8'h00;
        uval = 1'b1;
        apb(1, 8'h00, 1, r, e);
        exp_q.push_back(tel());
        trig_wait(1);
        apb(1, 8'h00, 2, r, e);
        uval = 1'b0;
        c = nfr;
        apb(1, 8'h00, 0, r, e);
        pstrb <= 4'hE;
        apb(1, 8'h00, 1, r, e);
        pstrb <= 4'hF;
        apb(1, 8'h00, 3, r, e);
        repeat (30) @(posedge pclk);
        chk(nfr, c, "ignored status");
        apb(1, 8'h00, 2, r, e);
        $display("test status byte done");
        for (i = 0; i < 5; i++) begin
            c = clrs;
            @(posedge pclk);
            errv <= 4'((i < 4) ? (1 << i) : 0);
            prm_rx_count <= (i == 4) ? 8'h20 : 8'h1F;
            prm_len_decl <= (i == 4) ? 8'h20 : 8'h1F;
            #1;
            exp_q.push_back(tel());
            trig_wait(1);
            chk(clrs, c + 1, "clear pulse");
            apb(0, 8'h0C, 0, r, e);
            chk(r, comm(1), "comm error");
            apb(0, 8'h10, 0, r, e);
            chk(r, 1, "ctrl flag");
            apb(1, 8'h10, 1, r, e);
            errv <= 4'h0;
            prm_rx_count <= 8'h1F;
            prm_len_decl <= 8'h1F;
            apb(0, 8'h0C, 0, r, e);
            chk(r, comm(0), "comm cleared");
        end
        chk(exp_q.size(), 0, "frames left");
        $display("test errors done");
        final_report();
    end
endmodule // tb_top
bind dpdiag_top dpdiag_properties #(.IDENT_NO(IDENT_NO)) chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .diag_req(diag_req),
    .buf_clear(buf_clear), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready));

// ### hdl/dpdiag_defs.svh
// Offsets, field positions, reset values and fixed codes of the diagnostic block
`ifndef DPDIAG_DEFS_SVH
`define DPDIAG_DEFS_SVH
`define DPD_OFS_DIAG_STAT 8'h00
`define DPD_OFS_USER_LO 8'h04
`define DPD_OFS_USER_HI 8'h08
`define DPD_OFS_COMM_STAT 8'h0C
`define DPD_OFS_CTRL 8'h10
`define DPD_RST_BYTE 8'h00
`define DPD_RST_WORD 32'h0000_0000
`define DPD_BIT_VALID 0
`define DPD_BIT_DELETE 1
`define DPD_STAT_IGNORE 8'h03
`define DPD_NO_MASTER 8'hFF
`define DPD_DEV_HDR 8'h0A
`define DPD_MSG_USER 8'h40
`define DPD_MSG_NONE 8'h00
`define DPD_PRM_MAX 8'h1F
`define DPD_LAST_IDX 4'hF
`define DPD_IDX_ZERO 4'h0
`define DPD_IDENT_DEFAULT 16'h5AA5 // Arbitrary value
`define DPD_CFG_CLR 0
`define DPD_ST0_NOT_READY 1
`define DPD_ST0_CFG_BAD 2
`define DPD_ST0_EXT_DIAG 3
`define DPD_ST0_UNSUPP 4
`define DPD_ST0_PRM_BAD 6
`define DPD_ST1_NEED_PRM 0
`define DPD_ST1_STAT_DIAG 1
`define DPD_ST1_FIXED_ONE 2
`define DPD_ST1_WD_ON 3
`define DPD_ST1_FREEZE 4
`define DPD_ST1_SYNC 5
`define DPD_ST2_OVERFLOW 7
`define DPD_CS0_CLEAR 0
`define DPD_CS0_PRM_FOUND 1
`define DPD_CS0_WD_ON 2
`define DPD_CS0_XFER 3
`define DPD_CS1_PRM_BAD 0
`define DPD_CS1_CFG_BAD 1
`define DPD_CS1_WD_EXP 2
`define DPD_CS1_HW_FAIL 3
`define DPD_CS1_DATA_EXCH 4
`define DPD_USER_TEL_BASE 11
`define DPD_USER_BYTES 5
`define DPD_TEL_BYTES 16
`endif

// ### hdl/dpdiag_pkg.sv
// Types shared by the diagnostic telegram block
package dpdiag_pkg;
    typedef enum logic [0:0] {
        DPD_IDLE = 1'b0,
        DPD_SEND = 1'b1
    } dpdiag_state_t;
    typedef logic [7:0] dpdiag_byte_t;
endpackage

// ### hdl/dpdiag_top.sv
// Diagnostic telegram framer with CPU-visible diagnostic block and status area
//
// Our own choices: register access over APB and the register offsets.
`include "dpdiag_defs.svh"

module dpdiag_top
    import dpdiag_pkg::*;
#(
    parameter logic [15:0] IDENT_NO = `DPD_IDENT_DEFAULT // Arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic diag_req,
    input wire logic not_ready,
    input wire logic ext_diag,
    input wire logic unsupported,
    input wire logic need_prm,
    input wire logic stat_diag,
    input wire logic freeze_held,
    input wire logic sync_held,
    input wire logic diag_overflow,
    input wire logic prm_done,
    input wire logic [7:0] master_addr,
    input wire logic [7:0] dev_err_code,
    input wire logic [7:0] prm_len_decl,
    input wire logic [7:0] prm_rx_count,
    input wire logic prm_found,
    input wire logic wd_active,
    input wire logic xfer_active,
    input wire logic cfg_mismatch,
    input wire logic wd_expired,
    input wire logic hw_fail,
    input wire logic data_exch,
    output logic buf_clear,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready
);

    logic [7:0] diag_status_byte_ff;
    logic [7:0] nxt_diag_status_byte;
    logic [39:0] user_diag_bytes_ff;
    logic [39:0] nxt_user_diag_bytes;
    logic user_valid_ff;
    logic clear_data_ff;
    logic err_prev_ff;
    logic pend_ff;
    logic buf_clear_ff;
    logic [31:0] prdata_ff;
    dpdiag_state_t state_ff;
    dpdiag_state_t nxt_state;
    logic [3:0] idx_ff;
    logic [7:0] tel_ff [0:15];
    logic [7:0] tel [0:15];
    logic [7:0] tx_byte_ff;
    logic [7:0] comm_status_low;
    logic [7:0] comm_status_high;
    logic acc;
    logic wr;
    logic rd;
    logic hit_stat;
    logic hit_lo;
    logic hit_hi;
    logic hit_comm;
    logic hit_ctrl;
    logic mapped;
    logic prm_bad;
    logic err_any;
    logic err_rise;
    logic start_diag;
    logic del_diag;
    logic start_send;
    logic done_send;
    logic wr_stat;
    logic stat_ignored;
    logic clr_wr;
    logic advance;
    logic [7:0] msg_code;

    // APB decode
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit_stat = (paddr == `DPD_OFS_DIAG_STAT);
    assign hit_lo = (paddr == `DPD_OFS_USER_LO);
    assign hit_hi = (paddr == `DPD_OFS_USER_HI);
    assign hit_comm = (paddr == `DPD_OFS_COMM_STAT);
    assign hit_ctrl = (paddr == `DPD_OFS_CTRL);
    assign mapped = hit_stat | hit_lo | hit_hi | hit_comm | hit_ctrl;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // Parameter length check
    assign prm_bad = (prm_len_decl != prm_rx_count) | (prm_rx_count > `DPD_PRM_MAX);
    // Error condition seen by the send logic
    assign err_any = prm_bad | cfg_mismatch | wd_expired | hw_fail | ~xfer_active;
    assign err_rise = err_any & ~err_prev_ff;

    // Status byte write decode
    assign wr_stat = wr & hit_stat & pstrb[0];
    assign nxt_diag_status_byte = wr_stat ? pwdata[7:0] : diag_status_byte_ff;
    assign stat_ignored = (nxt_diag_status_byte == `DPD_STAT_IGNORE);
    assign start_diag = wr_stat & ~stat_ignored
        & nxt_diag_status_byte[`DPD_BIT_VALID]
        & ~diag_status_byte_ff[`DPD_BIT_VALID];
    assign del_diag = wr_stat & ~stat_ignored
        & nxt_diag_status_byte[`DPD_BIT_DELETE];

    // User byte lanes; byte five sits alone in the upper word
    always_comb begin
        nxt_user_diag_bytes = user_diag_bytes_ff;
        if (wr & hit_lo) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    nxt_user_diag_bytes[8*i +: 8] = pwdata[8*i +: 8];
                end
            end
        end
        if (wr & hit_hi & pstrb[0]) begin
            nxt_user_diag_bytes[39:32] = pwdata[7:0];
        end
    end

    // Six-byte diagnostic block held for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_status_byte_ff <= `DPD_RST_BYTE;
            user_diag_bytes_ff <= 40'h00_0000_0000;
        end else begin
            diag_status_byte_ff <= nxt_diag_status_byte;
            user_diag_bytes_ff <= nxt_user_diag_bytes;
        end
    end

    // User diagnostic validity used for the message code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_valid_ff <= 1'b0;
        end else if (start_diag) begin
            user_valid_ff <= 1'b1;
        end else if (del_diag) begin
            user_valid_ff <= 1'b0;
        end
    end

    // Error edge and buffer clear pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_prev_ff <= 1'b0;
            buf_clear_ff <= 1'b0;
        end else begin
            err_prev_ff <= err_any;
            buf_clear_ff <= err_rise;
        end
    end
    assign buf_clear = buf_clear_ff;

    // Clear-data flag; a new error wins over a software clear
    assign clr_wr = wr & hit_ctrl & pstrb[0] & pwdata[`DPD_CFG_CLR];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_data_ff <= 1'b0;
        end else if (err_rise) begin
            clear_data_ff <= 1'b1;
        end else if (clr_wr) begin
            clear_data_ff <= 1'b0;
        end
    end

    // Communication status area
    always_comb begin
        comm_status_low = `DPD_RST_BYTE;
        comm_status_low[`DPD_CS0_CLEAR] = clear_data_ff;
        comm_status_low[`DPD_CS0_PRM_FOUND] = prm_found;
        comm_status_low[`DPD_CS0_WD_ON] = wd_active;
        comm_status_low[`DPD_CS0_XFER] = xfer_active;
        comm_status_high = `DPD_RST_BYTE;
        comm_status_high[`DPD_CS1_PRM_BAD] = prm_bad;
        comm_status_high[`DPD_CS1_CFG_BAD] = cfg_mismatch;
        comm_status_high[`DPD_CS1_WD_EXP] = wd_expired;
        comm_status_high[`DPD_CS1_HW_FAIL] = hw_fail;
        comm_status_high[`DPD_CS1_DATA_EXCH] = data_exch;
    end

    // Register read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `DPD_RST_WORD;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `DPD_OFS_DIAG_STAT: begin
                    prdata_ff <= {24'h00_0000, diag_status_byte_ff};
                end
                `DPD_OFS_USER_LO: begin
                    prdata_ff <= user_diag_bytes_ff[31:0];
                end
                `DPD_OFS_USER_HI: begin
                    prdata_ff <= {24'h00_0000, user_diag_bytes_ff[39:32]};
                end
                `DPD_OFS_COMM_STAT: begin
                    prdata_ff <= {16'h0000, comm_status_high, comm_status_low};
                end
                `DPD_OFS_CTRL: begin
                    prdata_ff <= {24'h00_0000, 7'h00, clear_data_ff};
                end
                default: begin
                    prdata_ff <= `DPD_RST_WORD;
                end
            endcase
        end
    end
    assign prdata = rd ? prdata_ff : `DPD_RST_WORD;

    // Device message code: an error code wins over the user diagnostic mark
    always_comb begin
        if (dev_err_code != `DPD_MSG_NONE) begin
            msg_code = dev_err_code;
        end else if (user_valid_ff | start_diag) begin
            msg_code = `DPD_MSG_USER;
        end else begin
            msg_code = `DPD_MSG_NONE;
        end
    end

    // Telegram contents
    always_comb begin
        tel[0] = `DPD_RST_BYTE;
        tel[0][`DPD_ST0_NOT_READY] = not_ready;
        tel[0][`DPD_ST0_CFG_BAD] = cfg_mismatch;
        tel[0][`DPD_ST0_EXT_DIAG] = ext_diag;
        tel[0][`DPD_ST0_UNSUPP] = unsupported;
        tel[0][`DPD_ST0_PRM_BAD] = prm_bad;
        tel[1] = `DPD_RST_BYTE;
        tel[1][`DPD_ST1_NEED_PRM] = need_prm;
        tel[1][`DPD_ST1_STAT_DIAG] = stat_diag;
        tel[1][`DPD_ST1_FIXED_ONE] = 1'b1;
        tel[1][`DPD_ST1_WD_ON] = wd_active;
        tel[1][`DPD_ST1_FREEZE] = freeze_held;
        tel[1][`DPD_ST1_SYNC] = sync_held;
        tel[2] = `DPD_RST_BYTE;
        tel[2][`DPD_ST2_OVERFLOW] = diag_overflow;
        tel[3] = prm_done ? master_addr : `DPD_NO_MASTER;
        tel[4] = IDENT_NO[15:8];
        tel[5] = IDENT_NO[7:0];
        tel[6] = `DPD_DEV_HDR;
        tel[7] = msg_code;
        tel[8] = `DPD_RST_BYTE;
        tel[9] = `DPD_RST_BYTE;
        tel[10] = `DPD_RST_BYTE;
        for (int i = 0; i < `DPD_USER_BYTES; i++) begin
            tel[`DPD_USER_TEL_BASE + i] = user_diag_bytes_ff[8*i +: 8];
        end
    end

    // Send sequencing
    assign start_send = (state_ff == DPD_IDLE) & (pend_ff | diag_req | err_rise | start_diag);
    assign done_send = (state_ff == DPD_SEND) & tx_ready & (idx_ff == `DPD_LAST_IDX);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DPD_IDLE: begin
                if (start_send) begin
                    nxt_state = DPD_SEND;
                end
            end
            DPD_SEND: begin
                if (done_send) begin
                    nxt_state = DPD_IDLE;
                end
            end
            default: begin
                nxt_state = DPD_IDLE;
            end
        endcase
    end

    // Requests arriving while busy are kept; a new one wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
        end else if ((state_ff == DPD_SEND) & (diag_req | err_rise | start_diag)) begin
            pend_ff <= 1'b1;
        end else if (start_send) begin
            pend_ff <= 1'b0;
        end
    end

    // A byte is taken and more remain
    assign advance = (state_ff == DPD_SEND) & tx_ready & ~done_send;

    // Send state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= DPD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Byte index within the telegram
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_ff <= `DPD_IDX_ZERO;
        end else if (start_send) begin
            idx_ff <= `DPD_IDX_ZERO;
        end else if (advance) begin
            idx_ff <= idx_ff + 4'h1;
        end
    end

    // Outgoing byte register, held until the sink takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte_ff <= `DPD_RST_BYTE;
        end else if (start_send) begin
            tx_byte_ff <= tel[0];
        end else if (advance) begin
            tx_byte_ff <= tel_ff[idx_ff + 4'h1];
        end
    end

    // Snapshot of the telegram so it stays consistent while it goes out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `DPD_TEL_BYTES; i++) begin
                tel_ff[i] <= `DPD_RST_BYTE;
            end
        end else if (start_send) begin
            for (int i = 0; i < `DPD_TEL_BYTES; i++) begin
                tel_ff[i] <= tel[i];
            end
        end
    end

    assign tx_valid = (state_ff == DPD_SEND);
    assign tx_byte = tx_byte_ff;
    assign tx_last = (state_ff == DPD_SEND) & (idx_ff == `DPD_LAST_IDX);

endmodule // dpdiag_top
